/* File: rtl/dpw_pkg.sv */
// Constants and types shared by the dual-port DRAM window decoder
package dpw_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DPW_BUS_AW = 24;
  localparam int DPW_DRAM_AW = 28;
  localparam int DPW_IO_AW = 16;
  localparam int DPW_WIN_LSB = 16;
  localparam int DPW_ALIAS_LSB = 20;

  // ---------------------------------------------------------------
  // Local I/O map
  // ---------------------------------------------------------------
  localparam logic [15:0] DPW_PAGE_IO = 16'h00ee;
  localparam logic [15:0] DPW_LOCK_IO = 16'h00ef;
  localparam int DPW_LOCK_BIT = 0;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] DPW_START_RST = 8'h00;
  localparam logic [3:0] DPW_ALIAS_RST = 4'h0;
  localparam logic [7:0] DPW_PAGE_RST = 8'h00;
  localparam logic DPW_LOCK_RST = 1'b0;
  localparam logic [7:0] DPW_END_2M = 8'h1f;
  localparam logic [7:0] DPW_END_4M = 8'h3f;
  localparam logic [7:0] DPW_END_8M = 8'h7f;
  localparam logic [7:0] DPW_END_BIG = 8'hf7;

  // Pages at or above this hold no DRAM yet
  localparam logic [7:0] DPW_DRAM_PAGES = 8'h04;

  // ---------------------------------------------------------------
  // Strap capture timing, in ref_clk cycles after reset release
  // ---------------------------------------------------------------
  // Strap synchroniser output is valid from the fourth edge; straps load on the fifth
  localparam logic [2:0] DPW_CFG_LOAD = 3'h4;
  localparam logic [2:0] DPW_CFG_WAIT = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUS = 2'b01,
    ST_LOCAL = 2'b10,
    ST_DONE = 2'b11
  } dpw_state_t;

  function automatic logic [7:0] dpw_end_default(input int mb);
    if (mb <= 2) begin
      return DPW_END_2M;
    end else if (mb <= 4) begin
      return DPW_END_4M;
    end else if (mb <= 8) begin
      return DPW_END_8M;
    end
    return DPW_END_BIG;
  endfunction : dpw_end_default

endpackage : dpw_pkg

/* File: rtl/dpw_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module dpw_sync3 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_q,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import dpw_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dpw_sync_t;

  dpw_sync_t s;
  dpw_sync_t next_s;

  // A bit moves only once stages two and three agree; stage one feeds
  // stage two alone so metastability never reaches the filter.
  always_comb begin
    next_s = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q = (s.s3 & ~(s.s2 ^ s.s3)) | (s.q & (s.s2 ^ s.s3));
  end

  always_ff @(posedge ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.q;

endmodule : dpw_sync3

/* File: rtl/dpw_window_decode.sv */
// Dual-port DRAM window decode, alias and page select
`timescale 1ns/1ns
// Notes on behaviour
// - Claim bus access only inside start..end window, 64 Kbyte granules.
// - Start above end disables the window entirely.
// - Limits compare against raw bus address, whatever page is selected.
// - DRAM offset is bus address plus alias, within selected page.
// - Alias sum wraps modulo 16 Mbytes; carry is dropped.
// - Page-select register at local I/O 0xEE picks the 16 Mbyte page.
// - Only local CPU or DMA can write page select; bus cannot.
// - Targets first 256 Mbytes; pages beyond 64 Mbytes flagged reserved.
// - Lock bit in I/O space holds dual-port DRAM for local bus.
// - No processor mode input affects window, alias or page.
// - Start, alias and page select reset to zero.
// - Window end defaults by DRAM size: 1f, 3f, 7f or f7 top byte.
// - Alias moves in whole 1 Mbyte steps only.
// - Own board's outgoing bus cycles never hit its own window.
module dpw_window_decode #(
  parameter int DRAM_MB = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] jmp_start,
  input wire logic [7:0] jmp_end,
  input wire logic [3:0] jmp_alias,
  input wire logic sb_req,
  input wire logic sb_wr,
  input wire logic [dpw_pkg::DPW_BUS_AW-1:0] sb_addr,
  input wire logic sb_own,
  output logic sb_ack,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [dpw_pkg::DPW_IO_AW-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic local_req,
  output logic local_gnt,
  output logic dram_req,
  output logic dram_wr,
  output logic [dpw_pkg::DPW_DRAM_AW-1:0] dram_addr,
  output logic dram_from_bus,
  output logic dram_rsvd,
  input wire logic dram_done
);
  import dpw_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dpw_state_t st;
    logic [2:0] cfg_cnt;
    logic [3:0] own_hist;
    logic [7:0] win_start;
    logic [7:0] win_end;
    logic [3:0] alias_mb;
    logic [7:0] page;
    logic lock;
    logic [DPW_BUS_AW-1:0] sb_addr_q;
    logic sb_ack;
    logic dram_req;
    logic dram_wr;
    logic dram_from_bus;
    logic dram_rsvd;
    logic local_gnt;
    logic [DPW_DRAM_AW-1:0] dram_addr;
    logic [7:0] io_rdata;
  } dpw_regs_t;

  localparam dpw_regs_t RST_S = '{
    st: ST_IDLE,
    cfg_cnt: 3'h0,
    own_hist: 4'h0,
    win_start: DPW_START_RST,
    win_end: dpw_end_default(DRAM_MB),
    alias_mb: DPW_ALIAS_RST,
    page: DPW_PAGE_RST,
    lock: DPW_LOCK_RST,
    sb_addr_q: '0,
    sb_ack: 1'b0,
    dram_req: 1'b0,
    dram_wr: 1'b0,
    dram_from_bus: 1'b0,
    dram_rsvd: 1'b0,
    local_gnt: 1'b0,
    dram_addr: '0,
    io_rdata: 8'h00
  };

  dpw_regs_t s;
  dpw_regs_t next_s;
  logic [1:0] rst_pipe;
  logic rst_q;
  logic [DPW_BUS_AW+1:0] bus_sync;
  logic [19:0] jmp_sync;
  logic bus_req;
  logic bus_wr;
  logic [DPW_BUS_AW-1:0] bus_addr;
  logic [DPW_BUS_AW-1:0] xlate;
  logic claim;
  logic bus_go;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_q = rst_pipe[1];

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Address and direction ride with the request, so they settle by the
  // time the request is seen; the far master must hold them meanwhile.
  dpw_sync3 #(.W(DPW_BUS_AW + 2)) u_bus_sync (
    .ref_clk(ref_clk),
    .rst_q(rst_q),
    .din({sb_req, sb_wr, sb_addr}),
    .dout(bus_sync)
  );

  dpw_sync3 #(.W(20)) u_jmp_sync (
    .ref_clk(ref_clk),
    .rst_q(rst_q),
    .din({jmp_start, jmp_end, jmp_alias}),
    .dout(jmp_sync)
  );

  assign bus_req = bus_sync[DPW_BUS_AW+1];
  assign bus_wr = bus_sync[DPW_BUS_AW];
  assign bus_addr = bus_sync[DPW_BUS_AW-1:0];

  // ---------------------------------------------------------------
  // Decode and translation
  // ---------------------------------------------------------------
  // Plain range test: start above end matches nothing.
  assign claim = (bus_addr[DPW_BUS_AW-1:DPW_WIN_LSB] >= s.win_start) &&
                 (bus_addr[DPW_BUS_AW-1:DPW_WIN_LSB] <= s.win_end);
  // 24-bit sum drops the carry out of the page.
  assign xlate = bus_addr + {s.alias_mb, 20'h00000};
  // Own cycles still drain through the synchroniser, so recent
  // ownership blocks a claim as well.
  assign bus_go = bus_req && !sb_own && (s.own_hist == 4'h0) && claim && !s.lock &&
                  (s.cfg_cnt == DPW_CFG_WAIT);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.own_hist = {s.own_hist[2:0], sb_own};
    // Straps are captured once; later jumper changes need a reset.
    if (s.cfg_cnt != DPW_CFG_WAIT) begin
      next_s.cfg_cnt = s.cfg_cnt + 3'h1;
      if (s.cfg_cnt == DPW_CFG_LOAD) begin
        next_s.win_start = jmp_sync[19:12];
        next_s.win_end = jmp_sync[11:4];
        next_s.alias_mb = jmp_sync[3:0];
      end
    end
    if (io_wr && io_addr == DPW_PAGE_IO) begin
      next_s.page = io_wdata;
    end
    if (io_wr && io_addr == DPW_LOCK_IO) begin
      next_s.lock = io_wdata[DPW_LOCK_BIT];
    end
    if (io_rd) begin
      if (io_addr == DPW_PAGE_IO) begin
        next_s.io_rdata = s.page;
      end else if (io_addr == DPW_LOCK_IO) begin
        next_s.io_rdata = {7'h00, s.lock};
      end else begin
        next_s.io_rdata = 8'h00;
      end
    end
    case (s.st)
      ST_IDLE: begin
        // Bus first; a locked or unclaimed bus cycle lets local through.
        if (bus_go) begin
          next_s.st = ST_BUS;
          next_s.sb_addr_q = bus_addr;
          next_s.dram_req = 1'b1;
          next_s.dram_wr = bus_wr;
          next_s.dram_from_bus = 1'b1;
          next_s.dram_addr = {s.page[3:0], xlate};
          next_s.dram_rsvd = (s.page >= DPW_DRAM_PAGES);
        end else if (local_req) begin
          next_s.st = ST_LOCAL;
          next_s.local_gnt = 1'b1;
        end
      end
      ST_BUS: begin
        if (dram_done) begin
          next_s.st = ST_DONE;
          next_s.dram_req = 1'b0;
          next_s.sb_ack = 1'b1;
        end
      end
      ST_DONE: begin
        if (!bus_req) begin
          next_s.st = ST_IDLE;
          next_s.sb_ack = 1'b0;
          next_s.dram_from_bus = 1'b0;
        end
      end
      ST_LOCAL: begin
        if (!local_req) begin
          next_s.st = ST_IDLE;
          next_s.local_gnt = 1'b0;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // No mode input exists, so decoding is mode independent.
  assign sb_ack = s.sb_ack;
  assign io_rdata = s.io_rdata;
  assign local_gnt = s.local_gnt;
  assign dram_req = s.dram_req;
  assign dram_wr = s.dram_wr;
  assign dram_addr = s.dram_addr;
  assign dram_from_bus = s.dram_from_bus;
  assign dram_rsvd = s.dram_rsvd;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_claim_in_window;
    @(posedge ref_clk) disable iff (!rst_q)
      $rose(s.dram_req) |-> (s.sb_addr_q[23:16] >= s.win_start) &&
                            (s.sb_addr_q[23:16] <= s.win_end);
  endproperty
  a_claim_in_window: assert property (p_claim_in_window)
    else $error("bus access claimed outside window");

  property p_disabled;
    @(posedge ref_clk) disable iff (!rst_q)
      (s.win_start > s.win_end) && (s.cfg_cnt == DPW_CFG_WAIT) |=> !$rose(s.dram_req);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled window claimed an access");

  property p_xlate;
    @(posedge ref_clk) disable iff (!rst_q)
      $rose(s.dram_req) |->
        s.dram_addr[23:0] == 24'(s.sb_addr_q + {s.alias_mb, 20'h00000});
  endproperty
  a_xlate: assert property (p_xlate)
    else $error("dram offset is not bus address plus alias");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rst_q)
      $rose(s.dram_req) |-> s.dram_addr[27:24] == s.page[3:0];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("alias carry spilled into page bits");

  property p_page_write;
    @(posedge ref_clk) disable iff (!rst_q)
      io_wr && (io_addr == DPW_PAGE_IO) |=> s.page == $past(io_wdata);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page select did not take the written value");

  property p_page_local;
    @(posedge ref_clk) disable iff (!rst_q)
      $changed(s.page) |-> $past(io_wr) && ($past(io_addr) == DPW_PAGE_IO);
  endproperty
  a_page_local: assert property (p_page_local)
    else $error("page select changed without a local write");

  property p_rsvd;
    @(posedge ref_clk) disable iff (!rst_q)
      $rose(s.dram_req) |-> s.dram_rsvd == (s.page >= DPW_DRAM_PAGES);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved page flag wrong");

  property p_lock;
    @(posedge ref_clk) disable iff (!rst_q)
      s.lock && (s.st == ST_IDLE) |=> s.st != ST_BUS;
  endproperty
  a_lock: assert property (p_lock)
    else $error("bus access started while locked");

  property p_own;
    @(posedge ref_clk) disable iff (!rst_q)
      sb_own && (s.st == ST_IDLE) |=> s.st != ST_BUS;
  endproperty
  a_own: assert property (p_own)
    else $error("own bus cycle claimed by own window");

  property p_excl;
    @(posedge ref_clk) disable iff (!rst_q)
      !(s.dram_req && s.local_gnt);
  endproperty
  a_excl: assert property (p_excl)
    else $error("bus and local both own the dram");

  property p_ack;
    @(posedge ref_clk) disable iff (!rst_q)
      (s.st == ST_BUS) && dram_done |=> s.sb_ack && !s.dram_req ##1 s.sb_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus acknowledge not given after dram done");

endmodule : dpw_window_decode

/* File: tb/dpw_bus_master.sv */
// Behavioural system-bus master driving the window decoder
`timescale 1ns/1ns
module dpw_bus_master (
  input wire logic ref_clk,
  input wire logic sb_ack,
  output logic sb_req,
  output logic sb_wr,
  output logic [dpw_pkg::DPW_BUS_AW-1:0] sb_addr
);
  import dpw_pkg::*;
  initial begin
    sb_req = 1'b0;
    sb_wr = 1'b0;
    sb_addr = 24'h000000;
  end
  // ----------------------------------------------------------
  // One access
  // ----------------------------------------------------------
  // Released lines show the inverse, so a stale address never matches
  task automatic access(input logic [23:0] a, input logic w, input int lim,
                        output logic acked);
    int n;
    acked = 1'b0;
    @(posedge ref_clk);
    sb_addr <= a;
    sb_wr <= w;
    sb_req <= 1'b1;
    for (n = 0; n < lim && !acked; n++) begin
      @(posedge ref_clk);
      acked = (sb_ack === 1'b1);
    end
    sb_req <= 1'b0;
    // Next access only once ack has gone
    for (n = 0; n < 20 && sb_ack !== 1'b0; n++) begin
      @(posedge ref_clk);
    end
    sb_addr <= ~a;
    sb_wr <= ~w;
  endtask : access
endmodule : dpw_bus_master

/* File: tb/dpw_window_decode_test.sv */
// Self-checking bench for the dual-port window decoder
`timescale 1ns/1ns
module dpw_window_decode_test;
  import dpw_pkg::*;
  typedef struct packed {
    logic [7:0] st;
    logic [7:0] en;
    logic [3:0] al;
    logic [7:0] pg;
    logic [23:0] a;
    logic w;
    logic hit;
    logic [27:0] ex;
  } dpw_row_t;
  localparam dpw_row_t ROWS [7] = '{
    '{8'h30, 8'h3f, 4'he, 8'h00, 24'h3a0000, 1'b0, 1'b1, 28'h01a0000},
    '{8'h30, 8'h3f, 4'he, 8'h02, 24'h3a0000, 1'b1, 1'b1, 28'h21a0000},
    '{8'h30, 8'h3f, 4'he, 8'h00, 24'h2fffff, 1'b0, 1'b0, 28'h0000000},
    '{8'h30, 8'h3f, 4'h0, 8'h00, 24'h3fffff, 1'b1, 1'b1, 28'h03fffff},
    '{8'h30, 8'h3f, 4'h0, 8'h00, 24'h400000, 1'b0, 1'b0, 28'h0000000},
    '{8'h40, 8'h3f, 4'h0, 8'h00, 24'h3f0000, 1'b0, 1'b0, 28'h0000000},
    '{8'h00, 8'hff, 4'hf, 8'h05, 24'hff0000, 1'b1, 1'b1, 28'h5ef0000}
  };
  logic ref_clk, rst_n, sb_req, sb_wr, sb_own, sb_ack, io_wr, io_rd;
  logic local_req, local_gnt, dram_req, dram_wr, dram_from_bus, dram_rsvd;
  logic dram_done, acked;
  logic [7:0] jmp_start, jmp_end, io_wdata, io_rdata, d;
  logic [3:0] jmp_alias;
  logic [23:0] sb_addr;
  logic [15:0] io_addr;
  logic [27:0] dram_addr;
  int mismatches = 0;
  int n_checks = 0;
  dpw_row_t r;

  dpw_window_decode #(.DRAM_MB(2)) uut (
    .ref_clk, .rst_n, .jmp_start, .jmp_end, .jmp_alias, .sb_req, .sb_wr,
    .sb_addr, .sb_own, .sb_ack, .io_wr, .io_rd, .io_addr, .io_wdata,
    .io_rdata, .local_req, .local_gnt, .dram_req, .dram_wr, .dram_addr,
    .dram_from_bus, .dram_rsvd, .dram_done
  );
  dpw_bus_master bm (.ref_clk, .sb_ack, .sb_req, .sb_wr, .sb_addr);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Generous: the whole run needs about 350 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [27:0] seen, input logic [27:0] ex);
    n_checks++;
    if (seen !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, seen);
    end
  endtask : check
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : do_reset
  task automatic io_write(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= 1'b1;
    @(posedge ref_clk);
    io_wr <= 1'b0;
  endtask : io_write
  task automatic io_read(input logic [15:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    @(posedge ref_clk);
    #1 v = io_rdata;
  endtask : io_read
  // DRAM controller side: answers a bus request with a one-cycle done
  task automatic serve(input logic hit, input logic [27:0] ex, input logic w, input int lim);
    int n;
    for (n = 0; n < lim && dram_req !== 1'b1; n++) @(posedge ref_clk);
    check("dram_req", 28'(dram_req), 28'(hit));
    if (dram_req === 1'b1) begin
      check("dram_addr", dram_addr, ex);
      check("dram_wr", 28'(dram_wr), 28'(w));
      check("dram_from_bus", 28'(dram_from_bus), 28'h1);
      dram_done <= 1'b1;
      @(posedge ref_clk);
      dram_done <= 1'b0;
    end
  endtask : serve
  task automatic run(input logic [23:0] a, input logic w, input logic hit, input logic [27:0] ex);
    fork
      bm.access(a, w, 20, acked);
      serve(hit, ex, w, 20);
    join
    check("sb_ack", 28'(acked), 28'(hit));
  endtask : run

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {jmp_start, jmp_end, jmp_alias, sb_own, io_wr, io_rd} = '0;
    {io_addr, io_wdata, local_req, dram_done} = '0;
    foreach (ROWS[i]) begin
      r = ROWS[i];
      jmp_start <= r.st;
      jmp_end <= r.en;
      jmp_alias <= r.al;
      do_reset();
      io_write(DPW_PAGE_IO, r.pg);
      io_read(DPW_PAGE_IO, d);
      check("page", 28'(d), 28'(r.pg));
      run(r.a, r.w, r.hit, r.ex);
      check("dram_rsvd", 28'(dram_rsvd), 28'(r.hit && (r.pg >= DPW_DRAM_PAGES)));
    end
    do_reset();
    io_read(DPW_PAGE_IO, d);
    check("page reset", 28'(d), 28'h0);
    io_read(16'h0010, d);
    check("unmapped", 28'(d), 28'h0);
    sb_own <= 1'b1;
    run(24'h100000, 1'b0, 1'b0, 28'h0);
    sb_own <= 1'b0;
    io_write(DPW_LOCK_IO, 8'h01);
    io_read(DPW_LOCK_IO, d);
    check("lock", 28'(d), 28'h1);
    fork
      bm.access(24'h100000, 1'b1, 80, acked);
      begin
        repeat (30) @(posedge ref_clk);
        check("locked dram_req", 28'(dram_req), 28'h0);
        io_write(DPW_LOCK_IO, 8'h00);
        serve(1'b1, 28'h0000000, 1'b1, 30);
      end
    join
    check("ack after unlock", 28'(acked), 28'h1);
    local_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("local_gnt", 28'(local_gnt), 28'h1);
    local_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("local_gnt off", 28'(local_gnt), 28'h0);
    give_verdict();
  end
endmodule : dpw_window_decode_test
